// file: src/synth_config_params.svh
// register offsets, field positions and timing constants of the configuration bank
`ifndef SYNTH_CONFIG_PARAMS_SVH
`define SYNTH_CONFIG_PARAMS_SVH

`define WORD_WIDTH 32
`define SEL_WIDTH 3
`define SEL_DIVISION 3'h0
`define SEL_PHASE 3'h1
`define SEL_MODULUS 3'h2
`define SEL_FUNCTION 3'h3
`define SEL_TIMEOUT 3'h4
`define FIELD12_WIDTH 12
`define FRACTIONAL_NUMERATOR_LSB 3
`define INT_LSB 15
`define TSEL_LSB 27
`define PHASE_LSB 3
`define MOD_LSB 3
`define RCNT_LSB 15
`define DOUBLER_BIT 20
`define HALVER_BIT 21
`define PRESCALER_BIT 22
`define PUMP_LSB 24
`define SLIP_BIT 28
`define NOISE_LSB 29
`define CRST_BIT 3
`define FLOAT_BIT 4
`define PDOWN_BIT 5
`define SENSE_BIT 6
`define PREC_BIT 7
`define HOLD_BIT 14
`define TDIV_LSB 7
`define TMODE_LSB 19
`define SYNC_STAGES 3
`define TIMEOUT_RESET 12'h000

`endif

// file: src/synth_config_pkg.sv
// types shared by the configuration bank
package synth_config_pkg;
  typedef enum logic [1:0] {
    NOISE_LOWEST = 2'h0,
    NOISE_RESERVED = 2'h1,
    NOISE_MIXED = 2'h2,
    NOISE_LOWEST_SPUR = 2'h3
  } noise_mode_t;
  typedef enum logic [1:0] {
    TDIV_OFF = 2'h0,
    TDIV_FAST_LOCK = 2'h1,
    TDIV_RESYNC = 2'h2,
    TDIV_RESERVED = 2'h3
  } timeout_mode_t;
  typedef enum logic [2:0] {
    LINK_IDLE = 3'b001,
    LINK_SHIFT = 3'b010,
    LINK_LOAD = 3'b100
  } link_state_t;
endpackage

// file: src/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync
  #(parameter int STAGES = 3)
  (
  input wire logic clock,
  input wire logic nrst,
  input wire logic pin,
  output logic level,
  output logic rise
  );
  logic [STAGES-1:0] chain_q;

  // the agreement filter reads stages two and three by index
  if (STAGES != 3)
    $error("pin_sync needs exactly three stages");

  // first stage only feeds the second; stages two and three must agree
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      chain_q <= '0;
      level <= 1'b0;
      rise <= 1'b0;
    end
    else
    begin
      chain_q <= {chain_q[STAGES-2:0], pin};
      rise <= 1'b0;
      if (chain_q[1] == chain_q[2] && chain_q[2] != level)
      begin
        level <= chain_q[2];
        rise <= chain_q[2];
      end
    end
  end
endmodule

// file: src/reference_path.sv
// reference doubler, five-bit counter and halver forming the comparator reference
`timescale 1ns/1ps
`include "synth_config_params.svh"
module reference_path
  (
  input wire logic clock,
  input wire logic nrst,
  input wire logic refLevel,
  input wire logic doubler,
  input wire logic halver,
  input wire logic [4:0] refCount,
  input wire logic hold,
  output logic compareRef
  );
  logic refPrev_q;
  logic [4:0] count_q;
  logic toggle_q;
  logic activeEdge;

  // without doubler only the falling edge counts; with it both edges do
  assign activeEdge = doubler ? (refLevel != refPrev_q) : (refPrev_q && !refLevel);

  always_ff @(posedge clock)
  begin
    if (!nrst)
      refPrev_q <= 1'b0;
    else
      refPrev_q <= refLevel;
  end

  // count code 0 divides by 32, 1..31 divide by themselves
  always_ff @(posedge clock)
  begin
    if (!nrst || hold)
    begin
      count_q <= 5'h00;
      toggle_q <= 1'b0;
      compareRef <= 1'b0;
    end
    else
    begin
      compareRef <= 1'b0;
      if (activeEdge)
      begin
        if (count_q == refCount - 5'h01)
        begin
          count_q <= 5'h00;
          toggle_q <= ~toggle_q;
          compareRef <= halver ? ~toggle_q : 1'b1;
        end
        else
          count_q <= count_q + 5'h01;
      end
    end
  end
endmodule

// file: src/synth_config_registers.sv
// serial-loaded configuration register bank of the synthesizer
`timescale 1ns/1ps
`include "synth_config_params.svh"

module synth_config_registers
  import synth_config_pkg::*;
  (
  input wire logic clock,
  input wire logic nrst,
  input wire logic serialData,
  input wire logic serialClock,
  input wire logic load_strobe,
  input wire logic reference_input,
  output logic [11:0] integerDivider,
  output logic [11:0] fractional_numerator,
  output logic [3:0] test_output_select,
  output logic [11:0] phaseWord,
  output logic [11:0] fractional_modulus,
  output logic [4:0] referenceCount,
  output logic doublerEnable,
  output logic reference_halver,
  output logic prescaler_select,
  output logic [3:0] pump_current_setting,
  output logic slip_reduction_enable,
  output logic [1:0] noiseMode,
  output logic ditherEnable,
  output logic modulator_restart_hold,
  output logic lock_precision_select,
  output logic detector_sense,
  output logic powerDown,
  output logic pump_float,
  output logic counterReset,
  output logic modulatorRestart,
  output logic [1:0] timeoutMode,
  output logic [11:0] timeoutDivider,
  output logic compareRef
  );
  logic [`WORD_WIDTH-1:0] shift_q;
  logic [`WORD_WIDTH-1:0] division_word_q;
  logic [`WORD_WIDTH-1:0] phase_word_setting_q;
  logic [`WORD_WIDTH-1:0] modulus_reference_config_q;
  logic [`WORD_WIDTH-1:0] function_control_q;
  logic [`WORD_WIDTH-1:0] timeout_divider_config_q;
  logic [`WORD_WIDTH-1:0] wordCapture;
  link_state_t state_q;
  logic dataLevel;
  logic clockLevel;
  logic clockRise;
  logic strobeRise;
  logic [2:0] selectBits;
  logic compareRefNext;

  function automatic logic [11:0] field12(input logic [`WORD_WIDTH-1:0] w, input int lsb);
    field12 = w[lsb +: 12];
  endfunction

  pin_sync #(.STAGES(`SYNC_STAGES)) syncData
  (
    .clock(clock),
    .nrst(nrst),
    .pin(serialData),
    .level(dataLevel),
    .rise()
  );

  pin_sync #(.STAGES(`SYNC_STAGES)) syncClock
  (
    .clock(clock),
    .nrst(nrst),
    .pin(serialClock),
    .level(clockLevel),
    .rise(clockRise)
  );

  pin_sync #(.STAGES(`SYNC_STAGES)) syncStrobe
  (
    .clock(clock),
    .nrst(nrst),
    .pin(load_strobe),
    .level(),
    .rise(strobeRise)
  );

  logic refLevel;

  pin_sync #(.STAGES(`SYNC_STAGES)) syncRef
  (
    .clock(clock),
    .nrst(nrst),
    .pin(reference_input),
    .level(refLevel),
    .rise()
  );

  // the serial clock passes the same synchroniser as data, keeping them aligned
  always_ff @(posedge clock)
  begin
    if (!nrst)
      shift_q <= '0;
    else if (clockRise)
      shift_q <= {shift_q[`WORD_WIDTH-2:0], dataLevel};
  end

  // link state only tracks activity; nothing here reads back to the host
  always_ff @(posedge clock)
  begin
    if (!nrst)
      state_q <= LINK_IDLE;
    else
    begin
      case (state_q)
        LINK_IDLE:
          if (clockRise)
            state_q <= LINK_SHIFT;
        LINK_SHIFT:
          if (strobeRise)
            state_q <= LINK_LOAD;
        LINK_LOAD:
          state_q <= clockRise ? LINK_SHIFT : LINK_IDLE;
        default:
          state_q <= LINK_IDLE;
      endcase
    end
  end

  assign wordCapture = shift_q;
  assign selectBits = wordCapture[`SEL_WIDTH-1:0];

  // latch copy on strobe rising edge; unused select codes are dropped
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      division_word_q <= '0;
      phase_word_setting_q <= '0;
      modulus_reference_config_q <= '0;
      function_control_q <= '0;
      timeout_divider_config_q <= '0;
    end
    else if (strobeRise)
    begin
      if (selectBits == `SEL_DIVISION)
        division_word_q <= wordCapture;
      else if (selectBits == `SEL_PHASE)
        phase_word_setting_q <= wordCapture;
      else if (selectBits == `SEL_MODULUS)
        modulus_reference_config_q <= wordCapture;
      else if (selectBits == `SEL_FUNCTION)
        function_control_q <= wordCapture;
      else if (selectBits == `SEL_TIMEOUT)
        timeout_divider_config_q <= wordCapture;
    end
  end

  // immediate settings follow their latch one cycle later
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      integerDivider <= 12'h000;
      fractional_numerator <= 12'h000;
      test_output_select <= 4'h0;
      noiseMode <= 2'h0;
      ditherEnable <= 1'b0;
      slip_reduction_enable <= 1'b0;
      prescaler_select <= 1'b0;
    end
    else
    begin
      integerDivider <= field12(division_word_q, `INT_LSB);
      fractional_numerator <= field12(division_word_q, `FRACTIONAL_NUMERATOR_LSB);
      test_output_select <= division_word_q[`TSEL_LSB +: 4];
      noiseMode <= modulus_reference_config_q[`NOISE_LSB +: 2];
      ditherEnable <= (noise_mode_t'(modulus_reference_config_q[`NOISE_LSB +: 2])
        == NOISE_LOWEST_SPUR);
      slip_reduction_enable <= modulus_reference_config_q[`SLIP_BIT];
      prescaler_select <= modulus_reference_config_q[`PRESCALER_BIT];
    end
  end

  // double-buffered settings move only when a division word lands
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      phaseWord <= 12'h000;
      fractional_modulus <= 12'h000;
      referenceCount <= 5'h00;
      doublerEnable <= 1'b0;
      reference_halver <= 1'b0;
      pump_current_setting <= 4'h0;
    end
    else if (strobeRise && selectBits == `SEL_DIVISION)
    begin
      phaseWord <= field12(phase_word_setting_q, `PHASE_LSB);
      fractional_modulus <= field12(modulus_reference_config_q, `MOD_LSB);
      referenceCount <= modulus_reference_config_q[`RCNT_LSB +: 5];
      doublerEnable <= modulus_reference_config_q[`DOUBLER_BIT];
      reference_halver <= modulus_reference_config_q[`HALVER_BIT];
      pump_current_setting <= modulus_reference_config_q[`PUMP_LSB +: 4];
    end
  end

  // function and timeout fields
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      modulator_restart_hold <= 1'b0;
      lock_precision_select <= 1'b0;
      detector_sense <= 1'b0;
      powerDown <= 1'b0;
      pump_float <= 1'b0;
      counterReset <= 1'b0;
      timeoutMode <= 2'h0;
      timeoutDivider <= `TIMEOUT_RESET;
    end
    else
    begin
      modulator_restart_hold <= function_control_q[`HOLD_BIT];
      lock_precision_select <= function_control_q[`PREC_BIT];
      detector_sense <= function_control_q[`SENSE_BIT];
      powerDown <= function_control_q[`PDOWN_BIT];
      pump_float <= function_control_q[`FLOAT_BIT] | function_control_q[`PDOWN_BIT];
      counterReset <= function_control_q[`CRST_BIT] | function_control_q[`PDOWN_BIT];
      timeoutMode <= timeout_divider_config_q[`TMODE_LSB +: 2];
      timeoutDivider <= field12(timeout_divider_config_q, `TDIV_LSB);
    end
  end

  // modulator restarts on each division word write unless held
  always_ff @(posedge clock)
  begin
    if (!nrst)
      modulatorRestart <= 1'b0;
    else
      modulatorRestart <= strobeRise && selectBits == `SEL_DIVISION
        && !function_control_q[`HOLD_BIT];
  end

  // reference path is held while counters are in reset or powered down
  reference_path refPath
  (
    .clock(clock),
    .nrst(nrst),
    .refLevel(refLevel),
    .doubler(doublerEnable),
    .halver(reference_halver),
    .refCount(referenceCount),
    .hold(counterReset),
    .compareRef(compareRefNext)
  );

  always_ff @(posedge clock)
  begin
    if (!nrst)
      compareRef <= 1'b0;
    else
      compareRef <= compareRefNext;
  end
endmodule

// file: tb/synth_config_properties.sv
// port-level assertions for the configuration bank
`timescale 1ns/1ps
module synth_config_properties
  (
  input wire logic clock,
  input wire logic nrst,
  input wire logic load_strobe,
  input wire logic [11:0] integerDivider,
  input wire logic [11:0] phaseWord,
  input wire logic [11:0] fractional_modulus,
  input wire logic [11:0] timeoutDivider,
  input wire logic lock_precision_select,
  input wire logic [1:0] noiseMode,
  input wire logic ditherEnable,
  input wire logic powerDown,
  input wire logic pump_float,
  input wire logic counterReset,
  input wire logic modulatorRestart,
  input wire logic modulator_restart_hold,
  input wire logic compareRef
  );
  logic strobePrev_q;
  logic [4:0] age_q;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  always_ff @(posedge clock)
  begin
    strobePrev_q <= load_strobe;
  end
  // cycles since the strobe pin rose; pin filter delay puts loads 2 to 12 later
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      age_q <= 5'h1F;
    end
    else if (load_strobe && !strobePrev_q)
    begin
      age_q <= 5'h00;
    end
    else if (age_q != 5'h1F)
    begin
      age_q <= age_q + 5'h01;
    end
  end
  a_division_load_time: assert property ($changed(integerDivider) |-> age_q inside {[2:12]})
    else $error("division word changed away from a strobe");
  a_phase_load_time: assert property ($changed(phaseWord) |-> age_q inside {[2:12]})
    else $error("phase word changed away from a strobe");
  a_modulus_load_time: assert property ($changed(fractional_modulus) |-> age_q inside {[2:12]})
    else $error("modulus changed away from a strobe");
  a_function_load_time: assert property ($changed(lock_precision_select) |-> age_q inside {[2:12]})
    else $error("function bit changed away from a strobe");
  a_timeout_load_time: assert property ($changed(timeoutDivider) |-> age_q inside {[2:12]})
    else $error("timeout divider changed away from a strobe");
  a_dither_follows_mode: assert property (ditherEnable == (noiseMode == 2'h3))
    else $error("dither does not match noise mode");
  a_powerdown_forces_pump: assert property (powerDown |-> pump_float && counterReset)
    else $error("power-down without float and counter reset");
  a_restart_one_cycle: assert property (modulatorRestart |=> !modulatorRestart)
    else $error("restart pulse longer than one cycle");
  a_restart_needs_clear: assert property (modulatorRestart |-> !modulator_restart_hold)
    else $error("restart pulse while hold set");
  a_restart_after_load: assert property (modulatorRestart |-> age_q inside {[2:12]})
    else $error("restart pulse without a load");
  a_reference_pulse: assert property (compareRef |=> !compareRef)
    else $error("comparator reference pulse too long");
  c_restart: cover property (modulatorRestart);
  c_powerdown: cover property (powerDown);
  c_dither: cover property (ditherEnable);
endmodule
bind synth_config_registers synth_config_properties synth_config_properties_inst (
  .clock(clock), .nrst(nrst), .load_strobe(load_strobe), .integerDivider(integerDivider),
  .phaseWord(phaseWord), .fractional_modulus(fractional_modulus),
  .timeoutDivider(timeoutDivider), .lock_precision_select(lock_precision_select),
  .noiseMode(noiseMode), .ditherEnable(ditherEnable), .powerDown(powerDown),
  .pump_float(pump_float), .counterReset(counterReset), .modulatorRestart(modulatorRestart),
  .modulator_restart_hold(modulator_restart_hold), .compareRef(compareRef));

// file: tb/serial_host.sv
// host model shifting configuration words into the bank
`timescale 1ns/1ps
module serial_host
  (
  input wire logic clock,
  output logic serialData,
  output logic serialClock,
  output logic load_strobe
  );
  initial
  begin
    serialData = 1'b0;
    serialClock = 1'b0;
    load_strobe = 1'b0;
  end
  // four cycles per level clears the three-flop pin filter
  task automatic writeWord(input logic [31:0] w);
    for (int i = 31; i >= 0; i--)
    begin
      serialData <= w[i];
      repeat (4) @(posedge clock);
      serialClock <= 1'b1;
      repeat (4) @(posedge clock);
      serialClock <= 1'b0;
    end
    repeat (4) @(posedge clock);
    serialData <= ~w[0];
    load_strobe <= 1'b1;
    repeat (4) @(posedge clock);
    load_strobe <= 1'b0;
    repeat (12) @(posedge clock);
  endtask
endmodule

// file: tb/synth_config_registers_tb_top.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ps
`include "synth_config_params.svh"
module synth_config_registers_tb_top;
  import synth_config_pkg::*;
  logic clock, nrst, serialData, serialClock, load_strobe, reference_input;
  logic [11:0] integerDivider, fractional_numerator, phaseWord, fractional_modulus, timeoutDivider;
  logic [3:0] test_output_select, pump_current_setting, refCnt;
  logic [4:0] referenceCount;
  logic [1:0] noiseMode, timeoutMode;
  logic doublerEnable, reference_halver, prescaler_select, slip_reduction_enable, ditherEnable;
  logic modulator_restart_hold, lock_precision_select, detector_sense, powerDown, pump_float;
  logic counterReset, modulatorRestart, compareRef;
  int err_total, tests_run, restarts, n;
  logic [31:0] fnWords [3] = '{32'h0000_0063, 32'h0000_005B, 32'h0000_40C3};
  logic [5:0] fnWant [3] = '{6'h0F, 6'h0B, 6'h38};
  logic [7:0] refRows [5] = '{8'h01, 8'h02, 8'h82, 8'h42, 8'h00};
  int refWant [5] = '{16, 32, 16, 64, 512};
  synth_config_registers synth_config_registers_inst (.clock(clock), .nrst(nrst),
    .serialData(serialData), .serialClock(serialClock), .load_strobe(load_strobe),
    .reference_input(reference_input), .integerDivider(integerDivider),
    .fractional_numerator(fractional_numerator), .test_output_select(test_output_select),
    .phaseWord(phaseWord), .fractional_modulus(fractional_modulus),
    .referenceCount(referenceCount), .doublerEnable(doublerEnable),
    .reference_halver(reference_halver), .prescaler_select(prescaler_select),
    .pump_current_setting(pump_current_setting), .slip_reduction_enable(slip_reduction_enable),
    .noiseMode(noiseMode), .ditherEnable(ditherEnable),
    .modulator_restart_hold(modulator_restart_hold),
    .lock_precision_select(lock_precision_select), .detector_sense(detector_sense),
    .powerDown(powerDown), .pump_float(pump_float), .counterReset(counterReset),
    .modulatorRestart(modulatorRestart), .timeoutMode(timeoutMode),
    .timeoutDivider(timeoutDivider), .compareRef(compareRef));
  serial_host serial_host_inst (.clock(clock), .serialData(serialData),
    .serialClock(serialClock), .load_strobe(load_strobe));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // reference square wave of sixteen cycles
  always @(posedge clock)
  begin
    refCnt <= refCnt + 4'h1;
    reference_input <= refCnt[3];
  end
  always @(posedge clock)
  begin
    if (modulatorRestart === 1'b1)
    begin
      restarts++;
    end
  end
  function automatic logic [31:0] divWord(input logic [3:0] t, input logic [11:0] i,
    input logic [11:0] f);
    return {1'b0, t, i, f, `SEL_DIVISION};
  endfunction
  function automatic logic [31:0] modWord(input logic [1:0] nz, input logic sl,
    input logic [3:0] pc, input logic ps, input logic hv, input logic db, input logic [4:0] rc);
    return {1'b0, nz, sl, pc, 1'b0, ps, hv, db, rc, 12'h041, `SEL_MODULUS};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // first interval after a change may be short, so the second one is kept
  task automatic measure(output int p);
    for (int k = 0; k < 1200 && compareRef !== 1'b1; k++) @(negedge clock);
    @(negedge clock);
    for (p = 1; p < 1200 && compareRef !== 1'b1; p++) @(negedge clock);
    if (p == 1200)
    begin
      err_total++;
      results;
    end
  endtask
  initial
  begin
    nrst = 1'b0;
    refCnt = 4'h0;
    reference_input = 1'b0;
    err_total = 0;
    tests_run = 0;
    restarts = 0;
    repeat (3) @(posedge clock);
    check(integerDivider, 12'h000);
    check(timeoutDivider, 12'h000);
    nrst <= 1'b1;
    @(posedge clock);
    serial_host_inst.writeWord(32'h0000_00C3);
    serial_host_inst.writeWord({17'h0, 12'h001, `SEL_PHASE});
    serial_host_inst.writeWord(modWord(2'h3, 1'b1, 4'hA, 1'b1, 1'b0, 1'b0, 5'h02));
    check(ditherEnable, 1'b1);
    check(slip_reduction_enable, 1'b1);
    check(prescaler_select, 1'b1);
    check(phaseWord, 12'h000);
    check(fractional_modulus, 12'h000);
    serial_host_inst.writeWord(divWord(4'h5, 12'h08A, 12'h01E));
    check(integerDivider, 12'h08A);
    check(fractional_numerator, 12'h01E);
    check(test_output_select, 4'h5);
    check(phaseWord, 12'h001);
    check(fractional_modulus, 12'h041);
    check(pump_current_setting, 4'hA);
    check(restarts, 1);
    $display("test double buffering done");
    for (int i = 0; i < 3; i++)
    begin
      serial_host_inst.writeWord(fnWords[i]);
      check({modulator_restart_hold, lock_precision_select, detector_sense, powerDown,
        pump_float, counterReset}, fnWant[i]);
    end
    serial_host_inst.writeWord(divWord(4'h5, 12'h08A, 12'h01E));
    check(restarts, 1);
    $display("test function register done");
    for (int m = 0; m < 3; m++)
    begin
      serial_host_inst.writeWord({11'h000, m[1:0], 12'hA50 + m[11:0], 4'h0, `SEL_TIMEOUT});
      check(timeoutMode, m[1:0]);
      check(timeoutDivider, 12'hA50 + m[11:0]);
    end
    for (int s = 5; s < 8; s++)
    begin
      serial_host_inst.writeWord({29'h1555_5555, s[2:0]});
      check(fractional_numerator, 12'h01E);
      check(timeoutDivider, 12'hA52);
      check(detector_sense, 1'b1);
    end
    $display("test timeout and unused codes done");
    for (int i = 0; i < 5; i++)
    begin
      serial_host_inst.writeWord(modWord(2'h0, 1'b0, 4'h1, 1'b1, refRows[i][6],
        refRows[i][7], refRows[i][4:0]));
      serial_host_inst.writeWord(divWord(4'h0, 12'h08A, 12'h01E));
      check(ditherEnable, 1'b0);
      measure(n);
      measure(n);
      check(n, refWant[i]);
    end
    $display("test reference path done");
    @(posedge clock);
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    @(negedge clock);
    check(integerDivider, 12'h000);
    $display("test second reset done");
    results;
  end
endmodule
